// ==== common/mff_pkg.sv ====
// constants and types of the MAC filter, flow-control and statistics block
// How it works
// - enable access, load index and data, write; busy clears itself.
// - address entries hold 48 bits, VLAN entries hold 12 bits.
// - enable access, load index, read; data appears as command clears.
// - only entries with a set valid bit match; filter-all checks every frame except broadcast.
// - multicast perfect mode accepts multicast only on an exact table hit.
// - no reset touches table contents; valid mask alone selects entries.
// - up to 32 interest multicast entries; hit index reported per frame.
// - transmit checksums inserted only when the descriptor requests them.
// - receive offload verifies found headers and flags any mismatch.
// - IPv4 only, in EtherType, 802.2 or SNAP; fragments get no checksum.
// - tagged frames are oversize only beyond maximum length plus 4.
// - insert tags on request; detect, optionally strip, report on receive.
// - four transmit queues, priority scheduler, optional non-blocking mode.
// - half duplex and busy: jam addressed incoming frames.
// - full duplex busy sends pause; on clear sends pause time zero.
// - valid pause: finish current frame, hold; zero time resumes early.
// - pause flow control only when negotiated and not disabled.
// - total receive counts every frame; good receive and transmit apart.
// - loss counter counts matched overruns, not frames refused at start.
// - frames under 64 bytes go to good or bad short counters; noise bad.
// - receive and transmit size bins; receive length includes the tag.
// - count received pause frames and self-generated control frames only.
// - interest hit index is 6 bits into the 64-entry table, 32 to 63.
// - read pointer reset, 32 reads through one port, clear on read.
package mff_pkg;
  localparam int ADDR_W = 48;
  localparam int VID_W = 12;
  localparam int ENTRIES = 64;
  localparam int IDX_W = 6;
  localparam int INTEREST_BASE = 32;
  localparam int LEN_W = 14;
  localparam logic [13:0] FRAME_MIN = 14'h0040;
  localparam logic [13:0] TAG_BYTES = 14'h0004;
  localparam logic [13:0] BIN_127 = 14'h007F;
  localparam logic [13:0] BIN_255 = 14'h00FF;
  localparam logic [13:0] BIN_511 = 14'h01FF;
  localparam logic [13:0] BIN_1023 = 14'h03FF;
  localparam logic [13:0] BIN_1518 = 14'h05EE;
  localparam int CLK_NS = 8;
  localparam int PAUSE_QUANTUM_NS = 512;
  localparam int PAUSE_QUANTUM_CYC = (PAUSE_QUANTUM_NS + CLK_NS - 1) / CLK_NS;
  localparam int NUM_CNT = 32;
  localparam int C_RX_ALL = 0;
  localparam int C_RX_OK = 1;
  localparam int C_TX_OK = 2;
  localparam int C_RX_LOSS = 3;
  localparam int C_SHORT_GOOD = 4;
  localparam int C_SHORT_BAD = 5;
  localparam int C_RX_BIN0 = 6;
  localparam int C_TX_BIN0 = 12;
  localparam int C_RX_PAUSE = 18;
  localparam int C_TX_CTRL = 19;
  localparam logic [2:0] BIN_NONE = 3'h7;
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_WAIT = 2'b01,
    PS_HOLD = 2'b11
  } mff_pause_t;
endpackage

// ==== logic/mff_top.sv ====
// filtering, checksum flags, VLAN, queues, flow control and statistics
`timescale 1ns/1ps
module mff_top import mff_pkg::*; #(
  parameter int CNT_W = 32,
  parameter int QUANTUM_CYC = PAUSE_QUANTUM_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic table_access_enable,
  input wire logic table_sel_vlan,
  input wire logic [IDX_W-1:0] table_entry_index,
  input wire logic [ADDR_W-1:0] table_wr_data,
  input wire logic table_write_req,
  input wire logic table_read_req,
  input wire logic [ENTRIES-1:0] table_entry_valid_mask,
  input wire logic multicast_perfect_accept,
  input wire logic filter_all_by_table,
  input wire logic rx_csum_enable,
  input wire logic rx_tag_strip_en,
  input wire logic [LEN_W-1:0] max_frame_length,
  input wire logic rx_frame_end,
  input wire logic [ADDR_W-1:0] rx_dest_addr,
  input wire logic [LEN_W-1:0] rx_frame_len,
  input wire logic rx_frame_err,
  input wire logic rx_tagged,
  input wire logic rx_ipv4,
  input wire logic rx_encap_ok,
  input wire logic rx_ip_frag,
  input wire logic rx_ip_sum_ok,
  input wire logic rx_l4_present,
  input wire logic rx_l4_sum_ok,
  input wire logic rx_overrun,
  input wire logic rx_full_at_start,
  input wire logic rx_noise,
  input wire logic rx_is_pause,
  input wire logic [15:0] rx_pause_time,
  input wire logic rx_addressed_start,
  input wire logic rx_busy,
  input wire logic full_duplex,
  input wire logic fc_negotiated,
  input wire logic fc_sw_enable,
  input wire logic [15:0] pause_time_cfg,
  input wire logic tx_desc_valid,
  input wire logic tx_ipck_req,
  input wire logic tx_tcpck_req,
  input wire logic tx_udpck_req,
  input wire logic tx_vtag_req,
  input wire logic tx_ipv4,
  input wire logic tx_ip_frag,
  input wire logic [3:0] tx_queue_ready,
  input wire logic tx_nonblock,
  input wire logic tx_frame_end,
  input wire logic tx_frame_ok,
  input wire logic [LEN_W-1:0] tx_frame_len,
  input wire logic stat_ptr_reset,
  input wire logic stat_rd,
  input wire logic [CNT_W-1:0] stat_threshold,
  output logic table_write_cmd,
  output logic table_read_cmd,
  output logic [ADDR_W-1:0] table_rd_data,
  output logic rx_status_valid,
  output logic rx_accept,
  output logic rx_interest_hit,
  output logic [IDX_W-1:0] interest_hit_index,
  output logic rx_csum_err,
  output logic rx_oversize,
  output logic rx_vtag,
  output logic rx_tag_stripped,
  output logic tx_ins_ip,
  output logic tx_ins_tcp,
  output logic tx_ins_udp,
  output logic tx_ins_vtag,
  output logic [3:0] tx_grant,
  output logic tx_pause_hold,
  output logic jam_send,
  output logic pause_send,
  output logic [15:0] pause_time_out,
  output logic [CNT_W-1:0] stat_data,
  output logic stat_event
);
  if (CNT_W < 8 || CNT_W > 32 || QUANTUM_CYC < 1 || QUANTUM_CYC > 255) begin
    $error("mff_top: unsupported CNT_W or QUANTUM_CYC");
  end

  function automatic logic [2:0] size_bin(input logic [LEN_W-1:0] n);
    if (n == FRAME_MIN) return 3'h0;
    else if (n > FRAME_MIN && n <= BIN_127) return 3'h1;
    else if (n > BIN_127 && n <= BIN_255) return 3'h2;
    else if (n > BIN_255 && n <= BIN_511) return 3'h3;
    else if (n > BIN_511 && n <= BIN_1023) return 3'h4;
    else if (n > BIN_1023 && n <= BIN_1518) return 3'h5;
    return BIN_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // entry table: no reset on storage so contents survive every reset
  logic [ADDR_W-1:0] addr_mem [ENTRIES];
  logic [VID_W-1:0] vid_mem [ENTRIES];
  logic [IDX_W-1:0] op_idx_q;
  logic [ADDR_W-1:0] op_data_q;
  logic op_vlan_q;

  always_ff @(posedge clk) begin
    if (table_write_cmd && !op_vlan_q) begin
      addr_mem[op_idx_q] <= op_data_q;
    end
    if (table_write_cmd && op_vlan_q) begin
      vid_mem[op_idx_q] <= op_data_q[VID_W-1:0];
    end
  end

  // a request while a command is pending is ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      table_write_cmd <= 1'b0;
      table_read_cmd <= 1'b0;
      op_idx_q <= '0;
      op_data_q <= '0;
      op_vlan_q <= 1'b0;
    end else if (table_write_cmd || table_read_cmd) begin
      table_write_cmd <= 1'b0;
      table_read_cmd <= 1'b0;
    end else if (table_access_enable) begin
      table_write_cmd <= table_write_req;
      table_read_cmd <= table_read_req && !table_write_req;
      op_idx_q <= table_entry_index;
      op_data_q <= table_wr_data;
      op_vlan_q <= table_sel_vlan;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      table_rd_data <= '0;
    end else if (table_read_cmd) begin
      table_rd_data <= op_vlan_q ? {36'h0, vid_mem[op_idx_q]} :
                       addr_mem[op_idx_q];
    end
  end

  tbl_wr_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    table_write_cmd |=> !table_write_cmd)
    else $error("write command did not clear");
  tbl_rd_data_a: assert property (@(posedge clk) disable iff (!arst_n)
    table_read_cmd && !op_vlan_q |=>
    table_rd_data == $past(addr_mem[op_idx_q]))
    else $error("read data not from indexed entry");

  ////////////////////////////////////////////////////////////////////////////
  // receive filtering, checksum status, tag status
  logic [ENTRIES-1:0] hit;
  logic [IDX_W-1:0] int_idx;
  logic is_mc, is_bc, any_hit, accept, cs_apply, cs_err;
  logic [LEN_W-1:0] limit;

  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      hit[i] = table_entry_valid_mask[i] &&
               (addr_mem[i] == rx_dest_addr);
    end
  end

  always_comb begin
    int_idx = '0;
    for (int i = ENTRIES - 1; i >= INTEREST_BASE; i--) begin
      if (hit[i]) int_idx = IDX_W'(i);
    end
  end

  always_comb begin
    is_bc = &rx_dest_addr;
    is_mc = rx_dest_addr[40] && !is_bc;
    any_hit = |hit;
    if (is_bc) accept = 1'b1;
    else if (filter_all_by_table) accept = any_hit;
    else if (is_mc) accept = !multicast_perfect_accept || any_hit;
    else accept = any_hit;
    cs_apply = rx_csum_enable && rx_ipv4 && rx_encap_ok &&
               !rx_ip_frag;
    cs_err = cs_apply && (!rx_ip_sum_ok ||
             (rx_l4_present && !rx_l4_sum_ok));
    limit = rx_tagged ? max_frame_length + TAG_BYTES :
            max_frame_length;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_status_valid <= 1'b0;
      rx_accept <= 1'b0;
      rx_interest_hit <= 1'b0;
      interest_hit_index <= '0;
      rx_csum_err <= 1'b0;
      rx_oversize <= 1'b0;
      rx_vtag <= 1'b0;
      rx_tag_stripped <= 1'b0;
    end else begin
      rx_status_valid <= rx_frame_end;
      if (rx_frame_end) begin
        rx_accept <= accept;
        rx_interest_hit <= is_mc &&
                           |hit[ENTRIES-1:INTEREST_BASE];
        interest_hit_index <= int_idx;
        rx_csum_err <= cs_err;
        rx_oversize <= rx_frame_len > limit;
        rx_vtag <= rx_tagged;
        rx_tag_stripped <= rx_tagged && rx_tag_strip_en;
      end
    end
  end

  csum_scope_a: assert property (@(posedge clk) disable iff (!arst_n)
    rx_status_valid && rx_csum_err |->
    $past(rx_ipv4 && !rx_ip_frag))
    else $error("checksum error outside IPv4 scope");
  oversize_tag_a: assert property (@(posedge clk) disable iff (!arst_n)
    rx_status_valid && rx_oversize && rx_vtag |->
    $past(rx_frame_len) > $past(max_frame_length) + TAG_BYTES)
    else $error("tagged frame flagged oversize within limit");

  ////////////////////////////////////////////////////////////////////////////
  // transmit descriptor requests
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ins_ip <= 1'b0;
      tx_ins_tcp <= 1'b0;
      tx_ins_udp <= 1'b0;
      tx_ins_vtag <= 1'b0;
    end else if (tx_desc_valid) begin
      tx_ins_ip <= tx_ipck_req && tx_ipv4 && !tx_ip_frag;
      tx_ins_tcp <= tx_tcpck_req && tx_ipv4 && !tx_ip_frag;
      tx_ins_udp <= tx_udpck_req && tx_ipv4 && !tx_ip_frag;
      tx_ins_vtag <= tx_vtag_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queue scheduler: queue 3 wins in strict mode; rotation avoids starving
  // low queues in non-blocking mode at the cost of strict latency
  mff_pause_t ps_q;
  logic [1:0] last_q, pick;
  logic found;

  always_comb begin
    pick = 2'h0;
    found = 1'b0;
    if (tx_nonblock) begin
      for (int k = 1; k <= 4; k++) begin
        if (!found && tx_queue_ready[2'(last_q + 2'(k))]) begin
          pick = 2'(last_q + 2'(k));
          found = 1'b1;
        end
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (tx_queue_ready[k]) pick = 2'(k);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_grant <= 4'h0;
      last_q <= 2'h3;
    end else if (tx_frame_end) begin
      tx_grant <= 4'h0;
    end else if (tx_grant == 4'h0 && ps_q == PS_IDLE && |tx_queue_ready) begin
      tx_grant <= 4'h1 << pick;
      last_q <= pick;
    end
  end

  grant_onehot_a: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot0(tx_grant))
    else $error("more than one queue granted");

  ////////////////////////////////////////////////////////////////////////////
  // flow control
  logic fc_on_q, busy_q, pause_ok;
  logic [15:0] quanta_q;
  logic [7:0] sub_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fc_on_q <= 1'b0;
      busy_q <= 1'b0;
      jam_send <= 1'b0;
      pause_send <= 1'b0;
      pause_time_out <= 16'h0000;
    end else begin
      fc_on_q <= fc_negotiated && fc_sw_enable && full_duplex;
      busy_q <= rx_busy;
      jam_send <= !full_duplex && rx_busy && rx_addressed_start;
      pause_send <= fc_on_q && (rx_busy != busy_q);
      if (fc_on_q && rx_busy != busy_q) begin
        pause_time_out <= rx_busy ? pause_time_cfg : 16'h0000;
      end
    end
  end

  assign pause_ok = rx_frame_end && rx_is_pause && !rx_frame_err && fc_on_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ps_q <= PS_IDLE;
      quanta_q <= 16'h0000;
      sub_q <= 8'h00;
    end else if (pause_ok) begin
      quanta_q <= rx_pause_time;
      sub_q <= 8'h00;
      if (rx_pause_time == 16'h0000) ps_q <= PS_IDLE;
      else if (ps_q == PS_IDLE && tx_grant != 4'h0) ps_q <= PS_WAIT;
      else if (ps_q == PS_IDLE) ps_q <= PS_HOLD;
    end else begin
      unique case (ps_q)
        PS_IDLE: ;
        PS_WAIT: if (tx_frame_end) ps_q <= PS_HOLD;
        PS_HOLD: begin
          if (sub_q == 8'(QUANTUM_CYC - 1)) begin
            sub_q <= 8'h00;
            quanta_q <= quanta_q - 16'h0001;
            if (quanta_q == 16'h0001) ps_q <= PS_IDLE;
          end else begin
            sub_q <= sub_q + 8'h01;
          end
        end
      endcase
    end
  end

  assign tx_pause_hold = ps_q[0];

  jam_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
    jam_send |-> $past(!full_duplex && rx_busy))
    else $error("jam without half duplex busy");
  resume_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    pause_send && pause_time_out == 16'h0000 |-> $past(!rx_busy, 1))
    else $error("zero pause sent while busy");
  hold_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    tx_pause_hold && tx_grant == 4'h0 |=> tx_grant == 4'h0)
    else $error("queue granted during pause hold");
  fc_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    pause_send |-> $past(fc_negotiated && fc_sw_enable, 2))
    else $error("pause sent without flow control");

  ////////////////////////////////////////////////////////////////////////////
  // statistics: clear on read, wrap on overflow
  logic [NUM_CNT-1:0] inc, at_thr;
  logic [CNT_W-1:0] cnt_q [NUM_CNT];
  logic [4:0] ptr_q;
  logic [2:0] rbin, tbin;
  logic rx_good;

  always_comb begin
    inc = '0;
    rx_good = rx_frame_end && !rx_frame_err && accept;
    rbin = size_bin(rx_frame_len);
    tbin = size_bin(tx_frame_len);
    inc[C_RX_ALL] = rx_frame_end;
    inc[C_RX_OK] = rx_good;
    inc[C_TX_OK] = tx_frame_end && tx_frame_ok;
    inc[C_RX_LOSS] = rx_frame_end && accept && rx_overrun &&
                     !rx_full_at_start;
    inc[C_SHORT_GOOD] = rx_frame_end && !rx_frame_err &&
                        rx_frame_len < FRAME_MIN;
    inc[C_SHORT_BAD] = rx_noise || (rx_frame_end && rx_frame_err &&
                       rx_frame_len < FRAME_MIN);
    for (int b = 0; b < 6; b++) begin
      inc[C_RX_BIN0 + b] = rx_good && rbin == 3'(b);
      inc[C_TX_BIN0 + b] = tx_frame_end && tx_frame_ok && tbin == 3'(b);
    end
    inc[C_RX_PAUSE] = rx_frame_end && rx_is_pause && !rx_frame_err;
    inc[C_TX_CTRL] = pause_send;
  end

  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    assign at_thr[g] = cnt_q[g] == stat_threshold - CNT_W'(1);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q[g] <= '0;
      end else if (stat_rd && ptr_q == 5'(g)) begin
        cnt_q[g] <= inc[g] ? CNT_W'(1) : '0;
      end else if (inc[g]) begin
        cnt_q[g] <= cnt_q[g] + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= 5'h00;
      stat_data <= '0;
      stat_event <= 1'b0;
    end else begin
      stat_event <= |(inc & at_thr);
      if (stat_ptr_reset) begin
        ptr_q <= 5'h00;
      end else if (stat_rd) begin
        stat_data <= cnt_q[ptr_q];
        ptr_q <= ptr_q + 5'h01;
      end
    end
  end

  stat_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    stat_rd && !stat_ptr_reset && !inc[ptr_q] |=>
    cnt_q[$past(ptr_q)] == '0 && stat_data == $past(cnt_q[ptr_q]))
    else $error("counter not returned and cleared on read");
  total_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    rx_frame_end && !(stat_rd && ptr_q == 5'h00) |=>
    cnt_q[C_RX_ALL] == $past(cnt_q[C_RX_ALL]) + CNT_W'(1))
    else $error("total receive count missed a frame");
endmodule

// ==== tb/mff_peer.sv ====
// remote station model: hands one finished receive frame to the block
`timescale 1ns/1ps
module mff_peer (
  input wire logic clk,
  output logic rx_frame_end,
  output logic [47:0] rx_dest_addr,
  output logic [13:0] rx_frame_len,
  output logic rx_tagged,
  output logic rx_ipv4,
  output logic rx_encap_ok,
  output logic rx_ip_frag,
  output logic rx_ip_sum_ok,
  output logic rx_l4_present,
  output logic rx_l4_sum_ok,
  output logic rx_frame_err,
  output logic rx_is_pause,
  output logic [15:0] rx_pause_time
);
  logic [86:0] f = '0;
  assign {rx_dest_addr, rx_frame_len, rx_tagged, rx_ipv4, rx_encap_ok,
    rx_ip_frag, rx_ip_sum_ok, rx_l4_present, rx_l4_sum_ok, rx_frame_err,
    rx_is_pause, rx_pause_time} = f;
  initial rx_frame_end = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // fields flip once the frame is over, so a late sample cannot pass
  task automatic frame(input logic [47:0] d, input logic [13:0] l,
    input logic [7:0] q, input logic [16:0] pz);
    @(negedge clk);
    rx_frame_end = 1'b1;
    f = {d, l, q, pz};
    @(negedge clk);
    rx_frame_end = 1'b0;
    f = ~f;
  endtask
endmodule

// ==== tb/mff_top_tb_top.sv ====
// self-checking bench of the filter, flow-control and statistics block
`timescale 1ns/1ps
module mff_top_tb_top import mff_pkg::*;;
  logic clk = 1'b0, arst_n = 1'b0;
  logic table_access_enable, table_sel_vlan, table_write_req, table_read_req;
  logic multicast_perfect_accept, filter_all_by_table, rx_csum_enable;
  logic rx_tag_strip_en, rx_addressed_start, rx_busy, full_duplex;
  logic fc_negotiated, fc_sw_enable, tx_desc_valid, tx_ipck_req;
  logic tx_tcpck_req, tx_udpck_req, tx_vtag_req, tx_ipv4, tx_ip_frag;
  logic tx_nonblock, tx_frame_end, tx_frame_ok, stat_ptr_reset, stat_rd;
  logic rx_overrun = 1'b0, rx_full_at_start = 1'b0, rx_noise = 1'b0;
  logic [IDX_W-1:0] table_entry_index, interest_hit_index;
  logic [ADDR_W-1:0] table_wr_data, table_rd_data, rx_dest_addr, da;
  logic [ENTRIES-1:0] table_entry_valid_mask;
  logic [LEN_W-1:0] max_frame_length = 14'h05EE, rx_frame_len, tx_frame_len;
  logic [15:0] rx_pause_time, pause_time_cfg, pause_time_out;
  logic [15:0] sd = 16'h0008, r1, r2;
  logic [3:0] tx_queue_ready, tx_grant, g, g0;
  logic [31:0] stat_threshold = 32'hFFFFFFFF, stat_data;
  logic rx_frame_end, rx_frame_err, rx_tagged, rx_ipv4, rx_encap_ok;
  logic rx_ip_frag, rx_ip_sum_ok, rx_l4_present, rx_l4_sum_ok, rx_is_pause;
  logic table_write_cmd, table_read_cmd, rx_status_valid, rx_accept;
  logic rx_interest_hit, rx_csum_err, rx_oversize, rx_vtag, rx_tag_stripped;
  logic tx_ins_ip, tx_ins_tcp, tx_ins_udp, tx_ins_vtag, tx_pause_hold;
  logic jam_send, pause_send, stat_event;
  int fails = 0, comparisons = 0, n, i, k;
  int unsigned ex[32];
  localparam logic [47:0] UA = 48'h0000_1234_5678, MA = 48'h0100_0000_00AB;
  localparam logic [47:0] PA = 48'h0180_C200_0001;
  localparam logic [13:0] LT[16] = '{14'h0028, 14'h003F, 14'h0040,
    14'h0041, 14'h007F, 14'h0080, 14'h00FF, 14'h0100, 14'h01FF, 14'h0200,
    14'h03FF, 14'h0400, 14'h05EE, 14'h05EF, 14'h05F2, 14'h05F3};
  mff_top #(.QUANTUM_CYC(2)) dut_u (.*);
  mff_peer peer_u (.*);
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int bin(input logic [13:0] l);
    if (l < 14'h0040 || l > 14'h05EE)
      return -1;
    return (l == 14'h0040) ? 0 : (l < 14'h0080) ? 1 : (l < 14'h0100) ? 2 :
      (l < 14'h0200) ? 3 : (l < 14'h0400) ? 4 : 5;
  endfunction
  function automatic logic acc(input logic [47:0] d, input logic h, pm, fa);
    if (&d)
      return 1'b1;
    if (fa)
      return h;
    return (d[40] && !pm) ? 1'b1 : h;
  endfunction
  task automatic chk(input logic [47:0] gv, ev);
    comparisons++;
    if (gv !== ev) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, gv, ev);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic lim(input int c);
    if (c >= 16) begin
      fails++;
      $display("unexpected timeout at %0t: %h %h", $time, c, 16);
      summarize();
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // refused requests show nothing, so the expected strobe is masked too
  task automatic tbl(input logic v, w, input logic [5:0] x,
    input logic [47:0] d);
    @(negedge clk);
    {table_sel_vlan, table_entry_index, table_wr_data} = {v, x, d};
    table_write_req = w;
    table_read_req = !w;
    @(negedge clk);
    {table_write_req, table_read_req} = 2'b00;
    chk({table_write_cmd, table_read_cmd},
      {w, !w} & {2{table_access_enable}});
    @(negedge clk);
    chk({table_write_cmd, table_read_cmd}, 2'b00);
  endtask
  task automatic rxf(input logic [47:0] d, input logic [13:0] l,
    input logic [7:0] q, input logic [16:0] pz);
    logic a, ih, h, ce, ov;
    ih = d === MA && table_entry_valid_mask[40];
    h = ih || (d === UA && table_entry_valid_mask[3]);
    a = acc(d, h, multicast_perfect_accept, filter_all_by_table);
    ce = rx_csum_enable & q[6] & q[5] & !q[4] & (!q[3] | q[2] & !q[1]);
    ov = l > max_frame_length + (q[7] ? 14'h0004 : 14'h0000);
    peer_u.frame(d, l, q, pz);
    chk({rx_status_valid, rx_accept}, {1'b1, a});
    chk({rx_csum_err, rx_oversize, rx_vtag, rx_tag_stripped},
      {ce, ov, q[7], q[7] & rx_tag_strip_en});
    chk({rx_interest_hit, ih ? interest_hit_index : 6'd40},
      {ih, 6'd40});
    ex[0]++;
    if (a && !q[0] && bin(l) >= 0)
      ex[6 + bin(l)]++;
    ex[1] += a && !q[0];
    if (l < 14'h0040)
      ex[q[0] ? 5 : 4]++;
    ex[18] += pz[16] && !q[0];
  endtask
  task automatic txf(input logic [13:0] l, input logic ok);
    for (n = 0; n < 16 && tx_grant === 4'h0; n++)
      @(negedge clk);
    lim(n);
    g = tx_grant;
    {tx_frame_end, tx_frame_ok, tx_frame_len} = {1'b1, ok, l};
    @(negedge clk);
    tx_frame_end = 1'b0;
    ex[2] += ok;
    if (ok && bin(l) >= 0)
      ex[12 + bin(l)]++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {table_access_enable, table_sel_vlan, table_write_req, table_read_req,
      multicast_perfect_accept, filter_all_by_table, rx_csum_enable,
      rx_tag_strip_en, rx_addressed_start, rx_busy, full_duplex,
      fc_negotiated, fc_sw_enable, tx_desc_valid, tx_ipck_req, tx_tcpck_req,
      tx_udpck_req, tx_vtag_req, tx_ipv4, tx_ip_frag, tx_nonblock,
      tx_frame_end, tx_frame_ok, stat_ptr_reset, stat_rd} = '0;
    {table_entry_index, table_wr_data, table_entry_valid_mask} = '0;
    {pause_time_cfg, tx_queue_ready, tx_frame_len} = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    table_access_enable = 1'b1;
    tbl(1'b0, 1'b1, 6'd3, UA);
    tbl(1'b0, 1'b1, 6'd40, MA);
    tbl(1'b1, 1'b1, 6'd5, 48'hFFFF_FFFF_FABC);
    table_access_enable = 1'b0;
    tbl(1'b0, 1'b1, 6'd3, 48'h0);
    table_access_enable = 1'b1;
    tbl(1'b1, 1'b0, 6'd5, 48'h0);
    chk(table_rd_data, 48'h0000_0000_0ABC);
    tbl(1'b0, 1'b0, 6'd40, 48'h0);
    chk(table_rd_data, MA);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    tbl(1'b0, 1'b0, 6'd3, 48'h0);
    chk(table_rd_data, UA);
    done("table");
    for (k = 0; k < 48; k++) begin
      sd = lfsr(sd);
      r1 = sd;
      sd = lfsr(sd);
      r2 = sd;
      case (r1[1:0])
        2'd0: da = UA;
        2'd1: da = MA;
        2'd2: da = '1;
        default: da = {7'h00, r1[2], 24'hC0FFEE, r2};
      endcase
      table_entry_valid_mask = {23'h0, r1[3], 36'h0, r1[4], 3'h0};
      {multicast_perfect_accept, filter_all_by_table} = r1[6:5];
      {rx_csum_enable, rx_tag_strip_en} = r1[8:7];
      rxf(da, LT[r1[12:9]], r2[7:0], 17'h0);
    end
    done("receive");
    for (k = 0; k < 8; k++) begin
      sd = lfsr(sd);
      @(negedge clk);
      tx_desc_valid = 1'b1;
      {tx_ipck_req, tx_tcpck_req, tx_udpck_req, tx_vtag_req, tx_ipv4,
        tx_ip_frag} = sd[5:0];
      @(negedge clk);
      tx_desc_valid = 1'b0;
      chk({tx_ins_ip, tx_ins_tcp, tx_ins_udp, tx_ins_vtag},
        {sd[5:3] & {3{sd[1] & !sd[0]}}, sd[2]});
    end
    tx_queue_ready = 4'b0101;
    txf(14'h0040, 1'b1);
    chk(g, 4'b0100);
    tx_nonblock = 1'b1;
    tx_queue_ready = 4'hF;
    txf(14'h0400, 1'b1);
    g0 = g;
    txf(14'h0640, 1'b0);
    tx_queue_ready = 4'h0;
    chk(g, {g0[2:0], g0[3]});
    done("transmit");
    for (k = 0; k < 2; k++) begin
      rx_busy = !k[0];
      @(negedge clk);
      rx_addressed_start = 1'b1;
      @(negedge clk);
      rx_addressed_start = 1'b0;
      chk(jam_send, !k[0]);
    end
    {full_duplex, fc_negotiated, fc_sw_enable} = 3'b111;
    sd = lfsr(sd);
    pause_time_cfg = sd;
    repeat (3) @(negedge clk);
    for (k = 0; k < 2; k++) begin
      @(negedge clk);
      rx_busy = !k[0];
      for (n = 0; n < 16 && pause_send !== 1'b1; n++)
        @(negedge clk);
      lim(n);
      chk(48'(n), 48'd1);
      chk(pause_time_out, k[0] ? 16'h0000 : pause_time_cfg);
      ex[19]++;
    end
    fc_sw_enable = 1'b0;
    repeat (3) @(negedge clk);
    rx_busy = 1'b1;
    for (n = 0; n < 4; n++) begin
      @(negedge clk);
      chk(pause_send, 1'b0);
    end
    rx_busy = 1'b0;
    repeat (4) @(negedge clk);
    fc_sw_enable = 1'b1;
    repeat (3) @(negedge clk);
    {multicast_perfect_accept, filter_all_by_table} = 2'b00;
    rxf(PA, 14'h0040, 8'h00, 17'h10010);
    repeat (3) @(negedge clk);
    chk(tx_pause_hold, 1'b1);
    rxf(PA, 14'h0040, 8'h00, 17'h10000);
    chk(tx_pause_hold, 1'b0);
    rxf(PA, 14'h0040, 8'h00, 17'h10001);
    chk(tx_pause_hold, 1'b1);
    for (n = 0; n < 16 && tx_pause_hold === 1'b1; n++)
      @(negedge clk);
    lim(n);
    done("flow");
    // the second pass proves that every read cleared its counter
    for (i = 0; i < 2; i++) begin
      @(negedge clk);
      stat_ptr_reset = 1'b1;
      @(negedge clk);
      stat_ptr_reset = 1'b0;
      for (k = 0; k < 32; k++) begin
        stat_rd = 1'b1;
        @(negedge clk);
        stat_rd = 1'b0;
        @(negedge clk);
        chk({16'h0, stat_data},
          48'(ex[k]));
        ex[k] = 0;
      end
      if (i == 0) begin
        // counters are all zero here, so a threshold of one fires at once
        stat_threshold = 32'h1;
        rx_overrun = 1'b1;
        rxf('1, 14'h0040, 8'h00, 17'h0);
        rx_overrun = 1'b0;
        ex[3]++;
        chk(stat_event, 1'b1);
        @(negedge clk);
        rx_noise = 1'b1;
        @(negedge clk);
        rx_noise = 1'b0;
        ex[5]++;
      end
    end
    done("statistics");
    summarize();
  end
endmodule
